// ---- rtl/pmc_loop_regs.sv ----
/*
  Loop control and status register bank with event interrupt, reached over
  classic Wishbone. Drives mode, reference, filter and realign pacing to
  the timing loop core. Assumes core status and dedicated control pins
  arrive asynchronously and are synchronised here.
*/
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

module pmc_loop_regs
  import pmc_pkg::*;
#(
  parameter int FAST_CYC = int'(PMC_FAST_STEP_CYC),
  parameter int SLOW_CYC = int'(PMC_SLOW_STEP_CYC)
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire pmc_pins_t pinsIn,
  input wire pmc_core_status_t coreStatusIn,
  output pmc_core_ctrl_t coreCtrl,
  output logic realignStrobe,
  output logic phaseStep,
  output logic realignBusy,
  output logic irq
);

  //////////////////////////////////////////////////////////////////////////
  // Parameter check
  generate
    if (FAST_CYC < 1 || SLOW_CYC < 1)
    begin : g_bad_pace
      $error("pmc_loop_regs: pacing intervals must be at least one cycle");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisation
  localparam int SYNC_W = $bits(pmc_pins_t) + $bits(pmc_core_status_t);

  logic [SYNC_W-1:0] syncedBits;
  pmc_pins_t pins;
  pmc_core_status_t coreStatus;

  pmc_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .asyncIn({pinsIn, coreStatusIn}),
    .syncOut(syncedBits)
  );

  assign pins = syncedBits[SYNC_W-1 -: $bits(pmc_pins_t)];
  assign coreStatus = syncedBits[$bits(pmc_core_status_t)-1:0];

  //////////////////////////////////////////////////////////////////////////
  // Wishbone slave
  logic request;
  logic [5:0] wordIdx;
  logic writeCommit;
  logic [7:0] readValue;

  assign request = wb_cyc_i && wb_stb_i;
  assign wordIdx = wb_adr_i[7:2];
  // Write lands on the edge the master sees ack
  assign writeCommit = request && wb_we_i && wb_ack_o && wb_sel_i[0];

  always_ff @(posedge clk)
  begin
    if (rst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= request && !wb_ack_o;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      wb_dat_o <= 32'h00000000;
    else if (request && !wb_ack_o)
      wb_dat_o <= {24'h000000, readValue};
  end

  //////////////////////////////////////////////////////////////////////////
  // Loop control register
  logic [7:0] loopControl;
  logic [7:0] loopStatus;
  logic [PMC_EV_WIDTH-1:0] eventStatus;
  logic [PMC_EV_WIDTH-1:0] eventMask;
  logic ctrlWrite;
  logic regAlignFall;

  assign ctrlWrite = writeCommit && (wordIdx == PMC_IDX_LOOP_CONTROL);
  // One to zero on the align bit
  assign regAlignFall = ctrlWrite && loopControl[PMC_CTL_ALIGN_BIT]
    && !wb_dat_i[PMC_CTL_ALIGN_BIT];

  always_ff @(posedge clk)
  begin
    if (rst)
      loopControl <= PMC_CTL_RESET;
    else if (ctrlWrite)
      loopControl <= wb_dat_i[7:0] & PMC_CTL_WRITE_MASK;
  end

  always_comb
  begin
    case (wordIdx)
      PMC_IDX_LOOP_CONTROL:
        readValue = loopControl;
      PMC_IDX_LOOP_STATUS:
        readValue = loopStatus;
      PMC_IDX_EVENT_STATUS:
        readValue = {3'h0, eventStatus};
      PMC_IDX_EVENT_MASK:
        readValue = {3'h0, eventMask};
      default:
        readValue = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Control source selection
  logic pinMode;
  logic pinAlignPrev;
  logic pinAlignFall;
  logic alignStart;
  pmc_core_ctrl_t selCtrl;
  pmc_mode_t selMode;
  pmc_mode_t next_mode;

  assign pinMode = pins.pinControlEnable;
  assign pinAlignFall = pinMode && pinAlignPrev && !pins.realignStrobe;
  assign alignStart = pinMode ? pinAlignFall : regAlignFall;

  always_ff @(posedge clk)
  begin
    if (rst)
      pinAlignPrev <= 1'b0;
    else
      pinAlignPrev <= pins.realignStrobe;
  end

  always_comb
  begin
    if (pinMode)
    begin
      selMode = pmc_mode_t'({pins.modeFieldHigh, pins.modeFieldLow});
      selCtrl.referenceSourceChoice = pins.referenceSourceChoice;
      selCtrl.filterCornerChoice = pins.filterCornerChoice;
    end
    else
    begin
      selMode = pmc_mode_t'({loopControl[PMC_CTL_MODE_HI_BIT],
        loopControl[PMC_CTL_MODE_LO_BIT]});
      selCtrl.referenceSourceChoice =
        loopControl[PMC_CTL_REFERENCE_SOURCE_CHOICE_BIT];
      selCtrl.filterCornerChoice = loopControl[PMC_CTL_FILTER_BIT];
    end
    // Failed reference in normal mode drops straight to holdover
    if (selMode == PMC_MODE_NORMAL && coreStatus.referenceFailed)
      next_mode = PMC_MODE_HOLDOVER;
    else
      next_mode = selMode;
    selCtrl.mode = next_mode;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      coreCtrl.referenceSourceChoice <= 1'b0;
      coreCtrl.mode <= PMC_MODE_FREERUN;
      coreCtrl.filterCornerChoice <= 1'b0;
    end
    else
      coreCtrl <= selCtrl;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      realignStrobe <= 1'b0;
    else
      realignStrobe <= alignStart;
  end

  //////////////////////////////////////////////////////////////////////////
  // Realignment pacing
  logic alignDone;

  pmc_slope_pacer #(
    .FAST_CYC(FAST_CYC),
    .SLOW_CYC(SLOW_CYC)
  ) u_pacer (
    .clk(clk),
    .rst(rst),
    .start(alignStart),
    .slowCorner(coreCtrl.filterCornerChoice),
    .phaseErrorPresent(coreStatus.phaseErrorPresent),
    .phaseStep(phaseStep),
    .busy(realignBusy),
    .done(alignDone)
  );

  //////////////////////////////////////////////////////////////////////////
  // Loop status register
  logic holdShown;
  logic lockShown;

  assign holdShown = coreStatus.coreHoldover
    || (coreCtrl.mode == PMC_MODE_HOLDOVER);
  assign lockShown = coreStatus.coreLocked && !holdShown;

  always_ff @(posedge clk)
  begin
    if (rst)
      loopStatus <= PMC_STS_RESET;
    else
    begin
      loopStatus <= 8'h00;
      loopStatus[PMC_STS_LOCK_BIT] <= lockShown;
      loopStatus[PMC_STS_HOLD_BIT] <= holdShown;
      // Unfiltered so short excursions stay visible
      loopStatus[PMC_STS_EDGE_BIT] <=
        coreStatus.trackingEdgeFlag;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Events and interrupt
  logic [PMC_EV_WIDTH-1:0] events;
  logic [PMC_EV_WIDTH-1:0] clearBits;
  logic [PMC_EV_WIDTH-1:0] next_eventStatus;
  logic lockPrev;
  logic holdPrev;
  logic edgePrev;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lockPrev <= 1'b0;
      holdPrev <= 1'b0;
      edgePrev <= 1'b0;
    end
    else
    begin
      lockPrev <= loopStatus[PMC_STS_LOCK_BIT];
      holdPrev <= loopStatus[PMC_STS_HOLD_BIT];
      edgePrev <= loopStatus[PMC_STS_EDGE_BIT];
    end
  end

  always_comb
  begin
    events = '0;
    events[PMC_EV_LOCK_GAIN] = loopStatus[PMC_STS_LOCK_BIT] && !lockPrev;
    events[PMC_EV_LOCK_LOSS] = !loopStatus[PMC_STS_LOCK_BIT] && lockPrev;
    events[PMC_EV_HOLD_ENTRY] = loopStatus[PMC_STS_HOLD_BIT] && !holdPrev;
    // Brief blips still latch here
    events[PMC_EV_EDGE] = loopStatus[PMC_STS_EDGE_BIT] && !edgePrev;
    events[PMC_EV_ALIGN_DONE] = alignDone;
  end

  assign clearBits = (writeCommit && (wordIdx == PMC_IDX_EVENT_STATUS))
    ? wb_dat_i[PMC_EV_WIDTH-1:0] : '0;
  // New event beats a clear in the same cycle
  assign next_eventStatus = (eventStatus & ~clearBits) | events;

  always_ff @(posedge clk)
  begin
    if (rst)
      eventStatus <= PMC_EV_RESET;
    else
      eventStatus <= next_eventStatus;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      eventMask <= PMC_EV_RESET;
    else if (writeCommit && (wordIdx == PMC_IDX_EVENT_MASK))
      eventMask <= wb_dat_i[PMC_EV_WIDTH-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(next_eventStatus & eventMask);
  end

endmodule : pmc_loop_regs

`default_nettype wire

// ---- rtl/pmc_pkg.sv ----
/*
  Constants, types and register layout for the timing loop control and
  status bank. Assumes a 40 MHz system clock and a 32-bit classic
  Wishbone register port in which each 8-bit register takes one word.
*/
// Operation
// - Control bit 7 picks primary (0) or secondary (1) reference; resets 0.
// - Control bits 4-3: normal, holdover, free-run, reserved; reset 10.
// - Control bit 2 picks loop corner 1.1 Hz (0) or 0.1 Hz (1).
// - Writing bit 0 from one to zero starts realignment of output clocks.
// - Realignment slews at most 41 ns per 1.326 ms, or 885 ns/s.
// - Status bit 5 is high while core loop is locked; the code holds it low whenever status bit 4 shows holdover.
// - Status bit 4 is high once core loop entered holdover.
// - Reference failure in normal mode forces holdover well within 0.750 us.
// - Status bit 2 is high at the +/-104 ppm tracking edge.
// - Tracking edge flag may blip briefly; it is passed through unfiltered.

package pmc_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Register indices, byte address is four times the index
  localparam logic [5:0] PMC_IDX_LOOP_CONTROL = 6'h00;
  localparam logic [5:0] PMC_IDX_LOOP_STATUS = 6'h01;
  localparam logic [5:0] PMC_IDX_EVENT_STATUS = 6'h02;
  localparam logic [5:0] PMC_IDX_EVENT_MASK = 6'h03;

  //////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int PMC_CTL_REFERENCE_SOURCE_CHOICE_BIT = 7;
  localparam int PMC_CTL_MODE_HI_BIT = 4;
  localparam int PMC_CTL_MODE_LO_BIT = 3;
  localparam int PMC_CTL_FILTER_BIT = 2;
  localparam int PMC_CTL_ALIGN_BIT = 0;
  localparam logic [7:0] PMC_CTL_WRITE_MASK = 8'h9D;
  localparam logic [7:0] PMC_CTL_RESET = 8'h10;
  localparam int PMC_STS_LOCK_BIT = 5;
  localparam int PMC_STS_HOLD_BIT = 4;
  localparam int PMC_STS_EDGE_BIT = 2;
  localparam logic [7:0] PMC_STS_RESET = 8'h00;

  localparam int PMC_EV_LOCK_GAIN = 0;
  localparam int PMC_EV_LOCK_LOSS = 1;
  localparam int PMC_EV_HOLD_ENTRY = 2;
  localparam int PMC_EV_EDGE = 3;
  localparam int PMC_EV_ALIGN_DONE = 4;
  localparam int PMC_EV_WIDTH = 5;
  localparam logic [4:0] PMC_EV_RESET = 5'h00;

  //////////////////////////////////////////////////////////////////////////
  // Realignment slope timing
  localparam longint PMC_CLK_MHZ = 40;
  localparam longint PMC_STEP_NS = 1;
  localparam longint PMC_FAST_SLOPE_NS = 41;
  localparam longint PMC_FAST_WINDOW_NS = 1326000;
  localparam longint PMC_SLOW_SLOPE_NS = 885;
  localparam longint PMC_SLOW_WINDOW_NS = 1000000000;
  localparam longint PMC_FAST_STEP_CYC =
    (PMC_FAST_WINDOW_NS * PMC_CLK_MHZ * PMC_STEP_NS / 1000
     + PMC_FAST_SLOPE_NS - 1) / PMC_FAST_SLOPE_NS;
  localparam longint PMC_SLOW_STEP_CYC =
    (PMC_SLOW_WINDOW_NS * PMC_CLK_MHZ * PMC_STEP_NS / 1000
     + PMC_SLOW_SLOPE_NS - 1) / PMC_SLOW_SLOPE_NS;

  //////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    PMC_MODE_NORMAL = 2'h0,
    PMC_MODE_HOLDOVER = 2'h1,
    PMC_MODE_FREERUN = 2'h2,
    PMC_MODE_RESERVED = 2'h3
  } pmc_mode_t;

  typedef struct packed {
    logic referenceSourceChoice;
    pmc_mode_t mode;
    logic filterCornerChoice;
  } pmc_core_ctrl_t;

  typedef struct packed {
    logic coreLocked;
    logic coreHoldover;
    logic trackingEdgeFlag;
    logic referenceFailed;
    logic phaseErrorPresent;
  } pmc_core_status_t;

  typedef struct packed {
    logic pinControlEnable;
    logic referenceSourceChoice;
    logic modeFieldHigh;
    logic modeFieldLow;
    logic filterCornerChoice;
    logic realignStrobe;
  } pmc_pins_t;

endpackage : pmc_pkg

// ---- rtl/pmc_slope_pacer.sv ----
/*
  Realignment pacer: permits one phase step per interval, the interval
  chosen by the loop corner. Assumes the core reports a phase error flag.
*/
`timescale 1ns/1ps
`default_nettype none

module pmc_slope_pacer
  import pmc_pkg::*;
#(
  parameter int FAST_CYC = int'(PMC_FAST_STEP_CYC),
  parameter int SLOW_CYC = int'(PMC_SLOW_STEP_CYC)
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic slowCorner,
  input wire logic phaseErrorPresent,
  output logic phaseStep,
  output logic busy,
  output logic done
);

  localparam int CW = $clog2((FAST_CYC > SLOW_CYC ? FAST_CYC : SLOW_CYC) + 1);

  generate
    if (FAST_CYC < 1 || SLOW_CYC < 1)
    begin : g_bad
      $error("pmc_slope_pacer: intervals must be at least one cycle");
    end
  endgenerate

  typedef enum logic [1:0] {
    PMC_PACE_IDLE = 2'b01,
    PMC_PACE_RUN = 2'b10
  } pmc_pace_t;

  pmc_pace_t state;
  logic [CW-1:0] count;
  logic [CW-1:0] limit;

  assign limit = slowCorner ? CW'(SLOW_CYC - 1) : CW'(FAST_CYC - 1);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= PMC_PACE_IDLE;
      count <= '0;
      phaseStep <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      phaseStep <= 1'b0;
      done <= 1'b0;
      case (state)
        PMC_PACE_IDLE:
        begin
          count <= '0;
          if (start)
            state <= PMC_PACE_RUN;
        end
        PMC_PACE_RUN:
        begin
          if (!phaseErrorPresent)
          begin
            state <= PMC_PACE_IDLE;
            done <= 1'b1;
          end
          else if (count >= limit)
          begin
            count <= '0;
            phaseStep <= 1'b1;
          end
          else
            count <= count + CW'(1);
        end
        default:
          state <= PMC_PACE_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      busy <= 1'b0;
    else
      busy <= (state == PMC_PACE_RUN) || start;
  end

endmodule : pmc_slope_pacer

`default_nettype wire

// ---- rtl/pmc_sync.sv ----
/*
  Two-flip-flop synchroniser for a vector of unrelated level inputs.
  Assumes each bit is an independent slow level.
*/
`timescale 1ns/1ps
`default_nettype none

module pmc_sync
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] firstStage;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      firstStage <= '0;
      syncOut <= '0;
    end
    else
    begin
      firstStage <= asyncIn;
      syncOut <= firstStage;
    end
  end

endmodule : pmc_sync

`default_nettype wire

// ---- tb/pmc_loop_regs_props.sv ----
/*
  Port checker for the loop control and status bank.
  Assumes it is bound into pmc_loop_regs and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module pmc_loop_regs_props
  import pmc_pkg::*;
#(
  parameter int FAST_CYC = 4,
  parameter int SLOW_CYC = 9
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire pmc_pins_t pinsIn,
  input wire pmc_core_status_t coreStatusIn,
  input wire pmc_core_ctrl_t coreCtrl,
  input wire logic realignStrobe,
  input wire logic phaseStep,
  input wire logic realignBusy,
  input wire logic irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  int gap;
  logic rdCtl;
  logic rdSts;
  assign rdCtl = wb_ack_o && !wb_we_i && wb_adr_i[7:2] == PMC_IDX_LOOP_CONTROL;
  assign rdSts = wb_ack_o && !wb_we_i && wb_adr_i[7:2] == PMC_IDX_LOOP_STATUS;
  // Cycles since the last phase step
  always_ff @(posedge clk)
    gap <= rst ? 100000 : (phaseStep ? 1 : gap + 1);
  //////////////////////////////////////////////////////////////////////////
  ack_delay_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ctl_rsv_a: assert property (rdCtl |-> wb_dat_o[31:8] == 24'h000000
    && wb_dat_o[6:5] == 2'h0 && !wb_dat_o[1]) else $error("ctl spare set");
  sts_rsv_a: assert property (rdSts |-> (wb_dat_o & 32'hFFFFFFCB) == 0)
    else $error("status spare set");
  hold_force_a: assert property (not ((coreCtrl.mode == PMC_MODE_NORMAL
    && coreStatusIn.referenceFailed && !pinsIn.pinControlEnable)[*8]))
    else $error("no holdover after reference loss");
  align_busy_a: assert property (realignStrobe |-> ##[0:1] realignBusy)
    else $error("realign start without busy");
  step_gap_a: assert property (phaseStep |-> realignBusy && gap >=
    (coreCtrl.filterCornerChoice ? SLOW_CYC : FAST_CYC))
    else $error("phase steps too close");
  pin_steer_a: assert property ((pinsIn.pinControlEnable
    && $stable(pinsIn) && !coreStatusIn.referenceFailed)[*5] |-> coreCtrl ==
    {pinsIn.referenceSourceChoice, pinsIn.modeFieldHigh, pinsIn.modeFieldLow,
    pinsIn.filterCornerChoice}) else $error("pins not steering core");
  cover property (realignStrobe);
  cover property (phaseStep);
  cover property ($rose(irq));
endmodule : pmc_loop_regs_props
bind pmc_loop_regs pmc_loop_regs_props #(.FAST_CYC(FAST_CYC),
  .SLOW_CYC(SLOW_CYC)) uProps (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .pinsIn(pinsIn), .coreStatusIn(coreStatusIn),
  .coreCtrl(coreCtrl), .realignStrobe(realignStrobe), .phaseStep(phaseStep),
  .realignBusy(realignBusy), .irq(irq));
`default_nettype wire

// ---- tb/tb_pmc_loop_regs.sv ----
/*
  Self-checking bench for the loop control and status bank.
  Assumes the bank is the only Wishbone slave, with short pacing counts.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samplesChecked++; if ((g) !== (e)) begin \
  nErrors++; $display("Error %s exp %0h got %0h", nm, e, g); end end
module tb_pmc_loop_regs
  import pmc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] datI = 32'h00000000;
  logic [31:0] datO;
  logic ack, rStb, pStep, rBusy, irq;
  pmc_pins_t pins = '0;
  pmc_core_status_t cst = '0;
  pmc_core_ctrl_t ctl;
  logic [7:0] q;
  int n;
  int nErrors = 0;
  int samplesChecked = 0;
  pmc_loop_regs #(.FAST_CYC(4), .SLOW_CYC(9)) uut (.clk(clk), .rst(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
    .pinsIn(pins), .coreStatusIn(cst), .coreCtrl(ctl), .realignStrobe(rStb),
    .phaseStep(pStep), .realignBusy(rBusy), .irq(irq));
  initial forever #12.5 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////
  task automatic reportAndStop;
    $display("comparisons %0d mismatches %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : reportAndStop
  // Waits on step, strobe, irq or ack, counting edges into n
  task automatic waitHi(input int which);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while ((which == 0 ? pStep : which == 1 ? rStb : which == 2 ? irq
      : ack) !== 1'b1 && n < 500);
    if (n >= 500)
    begin
      $display("Error wait limit reached");
      nErrors++;
      reportAndStop();
    end
  endtask : waitHi
  task automatic bus(input logic wr, input logic [5:0] idx,
    input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= {idx, 2'b00};
    datI <= {24'h000000, d};
    waitHi(3);
    q = datO[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask : settle
  //////////////////////////////////////////////////////////////////////////
  task automatic tFields;
    bus(0, PMC_IDX_LOOP_CONTROL, 8'h00);
    `CHK("ctl reset", 8'h10, q)
    `CHK("core reset", {1'b0, PMC_MODE_FREERUN, 1'b0}, ctl)
    bus(1, PMC_IDX_LOOP_CONTROL, 8'hFF);
    bus(0, PMC_IDX_LOOP_CONTROL, 8'h00);
    `CHK("ctl spare", 8'h9D, q)
    `CHK("core all", {1'b1, PMC_MODE_RESERVED, 1'b1}, ctl)
    for (int m = 0; m < 4; m++)
    begin
      bus(1, PMC_IDX_LOOP_CONTROL, {3'h0, m[1:0], 3'h0});
      settle();
      `CHK("core mode", {1'b0, pmc_mode_t'(m[1:0]), 1'b0}, ctl)
    end
    bus(0, 6'h05, 8'h00);
    `CHK("unmapped", 8'h00, q)
    $display("fields test done");
  endtask : tFields
  task automatic tStatus;
    bus(1, PMC_IDX_LOOP_CONTROL, 8'h10);
    cst.coreLocked <= 1'b1;
    settle();
    bus(0, PMC_IDX_LOOP_STATUS, 8'h00);
    `CHK("locked", 8'h20, q)
    cst.coreHoldover <= 1'b1;
    cst.trackingEdgeFlag <= 1'b1;
    settle();
    bus(0, PMC_IDX_LOOP_STATUS, 8'h00);
    `CHK("hold edge", 8'h14, q)
    `CHK("irq masked", 1'b0, irq)
    cst <= '0;
    settle();
    bus(0, PMC_IDX_LOOP_STATUS, 8'h00);
    `CHK("idle status", 8'h00, q)
    bus(1, PMC_IDX_LOOP_CONTROL, 8'h00);
    settle();
    cst.referenceFailed <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("forced hold", PMC_MODE_HOLDOVER, ctl.mode)
    bus(0, PMC_IDX_LOOP_STATUS, 8'h00);
    `CHK("hold bit", 1'b1, q[4])
    cst.referenceFailed <= 1'b0;
    bus(1, PMC_IDX_LOOP_CONTROL, 8'h10);
    $display("status test done");
  endtask : tStatus
  task automatic tRealign(input logic slow, input int gapExp);
    cst.phaseErrorPresent <= 1'b1;
    bus(1, PMC_IDX_EVENT_STATUS, 8'h1F);
    bus(1, PMC_IDX_EVENT_MASK, 8'h10);
    `CHK("irq before align", 1'b0, irq)
    bus(1, PMC_IDX_LOOP_CONTROL, {5'h02, slow, 2'h1});
    bus(1, PMC_IDX_LOOP_CONTROL, {5'h02, slow, 2'h0});
    `CHK("strobe lag", 1'b1, rStb)
    waitHi(0);
    waitHi(0);
    waitHi(0);
    `CHK("step gap", gapExp, n)
    `CHK("busy", 1'b1, rBusy)
    cst.phaseErrorPresent <= 1'b0;
    waitHi(2);
    bus(0, PMC_IDX_EVENT_STATUS, 8'h00);
    `CHK("done event", 1'b1, q[PMC_EV_ALIGN_DONE])
    bus(1, PMC_IDX_EVENT_STATUS, 8'h1F);
    settle();
    `CHK("irq clear", 1'b0, irq)
    `CHK("idle", 1'b0, rBusy)
    $display("realign test done");
  endtask : tRealign
  task automatic tPins;
    pins <= '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    settle();
    bus(1, PMC_IDX_LOOP_CONTROL, 8'h00);
    settle();
    `CHK("pin steer", {1'b1, PMC_MODE_HOLDOVER, 1'b1}, ctl)
    pins.realignStrobe <= 1'b1;
    settle();
    pins.realignStrobe <= 1'b0;
    waitHi(1);
    `CHK("pin align", 1'b1, n <= 6)
    pins <= '0;
    settle();
    `CHK("reg steer", {1'b0, PMC_MODE_NORMAL, 1'b0}, ctl)
    $display("pin test done");
  endtask : tPins
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    tFields();
    tStatus();
    tRealign(1'b0, 4);
    tRealign(1'b1, 9);
    tPins();
    reportAndStop();
  end
endmodule : tb_pmc_loop_regs
`default_nettype wire
